// file: bench/pem_front_model.sv
// front-end model: converter codes presented to the monitor
module pem_front_model (
   input wire logic [11:0] vin_i,
   input wire logic [11:0] vout_i,
   input wire logic [11:0] iout_i,
   output pem_pkg::pem_sample_t adc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // steady levels, a real converter holds its codes between samples
   assign adc_o = {vin_i, vout_i, iout_i};
endmodule // pem_front_model

// file: bench/tb_top.sv
// self-checking bench for the power energy monitor
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic hws = 1'b0;
   logic [31:0] rd;
   logic [31:0] q;
   logic ack, err, rng, pin, e;
   logic [11:0] vin = 12'h000;
   logic [11:0] vout = 12'h000;
   logic [11:0] iout = 12'h800;
   pem_pkg::pem_sample_t adc;
   logic [22:0] acc_m = 23'h0; // accumulator model, 23 bits; the monitor's always-zero top bit is left out
   logic [15:0] roll_m = 16'h0;
   logic [23:0] cnt_m = 24'h0;
   int num_errors = 0;
   int n_checks = 0;

   always #10 clk_i = ~clk_i;

   pem_front_model i_front (.vin_i(vin), .vout_i(vout), .iout_i(iout), .adc_o(adc));

   pem_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd), .dat_o(rd),
      .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(cyc), .ack_o(ack), .err_o(err),
      .hw_start_i(hws), .adc_i(adc), .range_high_o(rng), .multipurpose_alert_pin_o(pin));

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic fail(input string m);
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
         fail($sformatf("got %h exp %h", got, exp));
   endtask

   // one classic cycle; held until ack or err is seen at an edge
   task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      adr <= {a, 2'b00};
      we <= w;
      wd <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      q = rd;
      e = err;
      cyc <= 1'b0;
      we <= 1'b0;
      if (n >= 20)
      begin
         fail("bus timeout");
         wrap_up();
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      wb(a, 1'b0, 32'h0);
      chk(q, exp);
   endtask

   // pin is asynchronous; hold long enough for the synchroniser
   task automatic hw_pulse();
      hws <= 1'b1;
      repeat (4) @(posedge clk_i);
      hws <= 1'b0;
   endtask

   // single shot, then model power and energy
   task automatic sample(input logic [11:0] vi, input logic [11:0] io, input logic hw);
      logic [23:0] s;
      logic [22:0] p;
      int n;
      vin <= vi;
      iout <= io;
      @(posedge clk_i);
      if (hw)
         hw_pulse();
      else
         wb(6'h00, 1'b1, 32'h1);
      n = 0;
      do
      begin
         wb(6'h00, 1'b0, 32'h0);
         n++;
      end
      while (q[0] !== 1'b0 && n < 300);
      if (n >= 300)
      begin
         fail("sample timeout");
         wrap_up();
      end
      repeat (4) @(posedge clk_i);
      p = (io > 12'h800) ? 23'(vi * (io - 12'h800)) : 23'h0;
      s = {1'b0, acc_m} + {1'b0, p};
      acc_m = s[22:0];
      roll_m = roll_m + 16'(s[23]);
      cnt_m = cnt_m + 24'h1;
   endtask

   task automatic chk_energy();
      rd_chk(6'h09, {1'b0, acc_m[22:8], roll_m[7:0], 8'h00});
      rd_chk(6'h0a, {8'h00, cnt_m});
      rd_chk(6'h0b, {roll_m, 1'b0, acc_m[22:8]});
      rd_chk(6'h0c, {acc_m[7:0], cnt_m});
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(32'(rng), 32'h1);
      rd_chk(6'h11, 32'hfff);
      rd_chk(6'h12, 32'h0);
      rd_chk(6'h16, 32'h7fff);
      rd_chk(6'h02, 32'h1);
      wb(6'h18, 1'b0, 32'h0);
      chk(32'(e), 32'h1);
      wb(6'h00, 1'b1, 32'h2);
      wb(6'h01, 1'b1, 32'h2);
      vout <= 12'd50;
      sample(12'd100, 12'h814, 1'b0);
      chk(32'(rng), 32'h0);
      rd_chk(6'h04, 32'd100);
      rd_chk(6'h05, 32'd50);
      rd_chk(6'h08, 32'h7d0);
      rd_chk(6'h07, 32'h7);
      chk_energy();
      wb(6'h01, 1'b1, 32'h12);
      sample(12'd200, 12'h700, 1'b1);
      rd_chk(6'h08, 32'h0);
      // vout sampling off: the new code must not show up
      wb(6'h01, 1'b1, 32'h0);
      vout <= 12'd77;
      sample(12'd200, 12'h700, 1'b0);
      wb(6'h05, 1'b0, 32'h0);
      n_checks++;
      if (q === 32'd77)
         fail("vout sampled while disabled");
      sample(12'hfff, 12'hfff, 1'b0);
      sample(12'hfff, 12'hfff, 1'b0);
      chk_energy();
      rd_chk(6'h0d, 32'hfff);
      rd_chk(6'h0e, 32'hfff);
      wb(6'h0d, 1'b1, 32'h0);
      rd_chk(6'h0d, 32'h0);
      sample(12'd100, 12'h900, 1'b0);
      rd_chk(6'h0d, 32'h900);
      rd_chk(6'h0e, 32'hfff);
      wb(6'h11, 1'b1, 32'd100);
      sample(12'd100, 12'h900, 1'b0);
      rd_chk(6'h03, 32'h0);
      wb(6'h11, 1'b1, 32'd99);
      wb(6'h02, 1'b1, 32'h0101);
      sample(12'd100, 12'h900, 1'b0);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h1);
      wb(6'h02, 1'b1, 32'h0001);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h0);
      wb(6'h02, 1'b1, 32'h0004);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h1);
      wb(6'h02, 1'b1, 32'h0100);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h0);
      wb(6'h02, 1'b1, 32'h0002);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h1);
      sample(12'd50, 12'h900, 1'b0);
      rd_chk(6'h03, 32'h1);
      chk(32'(pin), 32'h0);
      wb(6'h17, 1'b1, 32'h0);
      rd_chk(6'h03, 32'h0);
      sample(12'd100, 12'h900, 1'b0);
      // current 0x100 above limit 0x0ff keeps a second live condition
      wb(6'h15, 1'b1, 32'h0ff);
      wb(6'h17, 1'b1, 32'h0);
      rd_chk(6'h03, 32'h11);
      // continuous run from the pin, then stopped by command
      wb(6'h00, 1'b1, 32'h2);
      wb(6'h01, 1'b1, 32'h1);
      hw_pulse();
      repeat (600) @(posedge clk_i);
      wb(6'h00, 1'b1, 32'h2);
      repeat (400) @(posedge clk_i);
      rd_chk(6'h00, 32'h0);
      wb(6'h0a, 1'b0, 32'h0);
      n_checks++;
      if (q[23:0] <= cnt_m + 24'h1)
         fail("continuous mode did not repeat");
      wrap_up();
   end
endmodule // tb_top

// file: common/pem_consts.svh
// register offsets, reset values and timing counts of the power monitor
`ifndef PEM_CONSTS_SVH
`define PEM_CONSTS_SVH
`define PEM_A_CTRL 6'h00
`define PEM_A_SETUP 6'h01
`define PEM_A_ALERT 6'h02
`define PEM_A_STATUS 6'h03
`define PEM_A_VIN 6'h04
`define PEM_A_VOUT 6'h05
`define PEM_A_IOUT 6'h06
`define PEM_A_PWR 6'h07
`define PEM_A_PWR_WIDE 6'h08
`define PEM_A_EN_SHORT0 6'h09
`define PEM_A_EN_SHORT1 6'h0a
`define PEM_A_EN_WIDE0 6'h0b
`define PEM_A_EN_WIDE1 6'h0c
`define PEM_A_PK_IOUT 6'h0d
`define PEM_A_PK_VIN 6'h0e
`define PEM_A_PK_VOUT 6'h0f
`define PEM_A_PK_PWR 6'h10
`define PEM_A_VIN_OV 6'h11
`define PEM_A_VIN_UV 6'h12
`define PEM_A_VOUT_OV 6'h13
`define PEM_A_VOUT_UV 6'h14
`define PEM_A_IOUT_OC 6'h15
`define PEM_A_PWR_OP 6'h16
`define PEM_A_CLEAR 6'h17
`define PEM_OV_RESET 12'hfff
`define PEM_UV_RESET 12'h000
`define PEM_PWR_OP_RESET 16'h7fff
`define PEM_CUR_ZERO 12'h800
`define PEM_CONV_NS 1000
`define PEM_CLK_NS 20
`define PEM_CONV_CYC ((`PEM_CONV_NS) / (`PEM_CLK_NS))
`define PEM_NSTAT 6
`endif

// file: common/pem_pkg.sv
// types shared by the power energy monitor files
package pem_pkg;
   typedef enum logic [1:0] {PEM_PIN_GPO, PEM_PIN_ALERT, PEM_PIN_CMP} pem_pin_mode_t;
   typedef struct packed {
      logic [11:0] vin;
      logic [11:0] vout;
      logic [11:0] iout;
   } pem_sample_t;
   typedef struct packed {
      logic [23:0] acc;
      logic [15:0] roll;
      logic [23:0] cnt;
   } pem_energy_t;
endpackage

// file: rtl/pem_conv.sv
// sampling sequencer: paces conversions and averages the adc codes
`include "pem_consts.svh"
module pem_conv (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic continuous_i,
   input wire logic vout_en_i,
   input wire logic [1:0] avg_i,
   input wire pem_pkg::pem_sample_t adc_i,
   output logic busy_o,
   output logic done_o,
   output pem_pkg::pem_sample_t avg_o
);
   logic [$clog2(`PEM_CONV_CYC+1)-1:0] tick;
   logic [3:0] nsamp;
   logic [15:0] sum_vin;
   logic [15:0] sum_vout;
   logic [15:0] sum_iout;
   logic last;
   assign last = nsamp == ((4'h1 << avg_i) - 4'h1);

   // pacing of one conversion per tick, averaging over 1,2,4 or 8 codes
   always_ff @(posedge clk_i)
   begin
      done_o <= 1'b0;
      if (rst_i || stop_i)
      begin
         busy_o <= 1'b0;
         tick <= '0;
         nsamp <= 4'h0;
         sum_vin <= 16'h0000;
         sum_vout <= 16'h0000;
         sum_iout <= 16'h0000;
      end
      else if (!busy_o)
      begin
         busy_o <= start_i;
      end
      else if (tick != ($clog2(`PEM_CONV_CYC+1))'(`PEM_CONV_CYC - 1))
      begin
         tick <= tick + 1'b1;
      end
      else
      begin
         tick <= '0;
         if (last)
         begin
            // shift divides by the power-of-two sample count
            avg_o.vin <= 12'((sum_vin + {4'h0, adc_i.vin}) >> avg_i);
            avg_o.iout <= 12'((sum_iout + {4'h0, adc_i.iout}) >> avg_i);
            avg_o.vout <= vout_en_i ? 12'((sum_vout + {4'h0, adc_i.vout}) >> avg_i) : 12'h000;
            done_o <= 1'b1;
            nsamp <= 4'h0;
            sum_vin <= 16'h0000;
            sum_vout <= 16'h0000;
            sum_iout <= 16'h0000;
            busy_o <= continuous_i;
         end
         else
         begin
            nsamp <= nsamp + 4'h1;
            sum_vin <= sum_vin + {4'h0, adc_i.vin};
            sum_vout <= sum_vout + {4'h0, adc_i.vout};
            sum_iout <= sum_iout + {4'h0, adc_i.iout};
         end
      end
   end
endmodule // pem_conv

// file: rtl/pem_monitor.sv
// power and energy monitor with status, peaks and alert pin behind wishbone
// What this block does
// - clear command drops each latched status bit whose condition has ended.
// - a condition still present sets its status bit again right after clearing.
// - status bits latch when set and hold until a clear command.
// - alert pin offers general output, alert and comparator modes.
// - comparator mode drives the pin from selected value against its threshold.
// - alert mask bits pick alerting status bits; a separate select picks the comparator condition.
// - general output mode ignores masks; pin follows software only.
// - setup selects single/continuous, vout enable, input range, averaging.
// - sampling starts from a hardware input or the run command.
// - input voltage always sampled, output voltage only when enabled.
// - 12-bit vin times non-negative 12-bit current gives 24-bit power.
// - wide power read gives 24 bits, normal read upper 16, MSB zero.
// - each power value adds into a 24-bit accumulator, MSB kept zero.
// - accumulator wrap increments a 16-bit wrapping rollover counter.
// - 24-bit sample counter counts each accumulated power value.
// - short energy read: upper 16 accumulator, low 8 rollover, 24 count.
// - wide energy read: 24 accumulator, 16 rollover, 24 count bits.
// - peaks hold maxima since clear, update per averaged result; zero write clears.
// - warnings trigger only on strictly above or strictly below thresholds.
// - thresholds reset to min/max scale so no warning asserts by default.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`include "pem_consts.svh"
module pem_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic err_o,
   input wire logic hw_start_i,
   input wire pem_pkg::pem_sample_t adc_i,
   output logic range_high_o,
   output logic multipurpose_alert_pin_o
);
   // setup and control
   logic continuous;
   logic vout_en;
   logic range_high;
   logic [1:0] avg;
   logic sw_start;
   logic sw_stop;
   pem_pkg::pem_pin_mode_t pin_mode;
   logic gpo_level;
   logic [`PEM_NSTAT-1:0] alert_mask;
   logic [2:0] cmp_sel;
   // thresholds
   logic [11:0] vin_ov;
   logic [11:0] vin_uv;
   logic [11:0] vout_ov;
   logic [11:0] vout_uv;
   logic [11:0] iout_oc;
   logic [15:0] pwr_op;
   // measurements
   pem_pkg::pem_sample_t meas;
   logic [23:0] pwr_wide;
   pem_pkg::pem_energy_t en;
   logic [11:0] pk_iout;
   logic [11:0] pk_vin;
   logic [11:0] pk_vout;
   logic [15:0] pk_pwr;
   logic [`PEM_NSTAT-1:0] status;
   logic [`PEM_NSTAT-1:0] cond;
   logic [`PEM_NSTAT-1:0] next_status;
   logic hw_meta;
   logic hw_sync;
   logic hw_prev;
   logic busy;
   logic done;
   logic pwr_valid;
   pem_pkg::pem_sample_t avg_s;
   logic bus_wr;
   logic bus_rd;
   logic clear_cmd;
   logic map_hit;
   logic [31:0] rd_word;
   logic [11:0] cur_pos;
   logic [23:0] next_pwr;
   logic [24:0] acc_sum;
   logic [15:0] pwr_norm;

   // positive part of offset-binary current; negative gives no power
   function automatic logic [11:0] pos_current(input logic [11:0] code);
      pos_current = code > `PEM_CUR_ZERO ? 12'(code - `PEM_CUR_ZERO) : 12'h000;
   endfunction

   // strictly-above test shared by warnings and peak tracking
   function automatic logic above(input logic [15:0] v, input logic [15:0] lim);
      above = v > lim;
   endfunction

   assign bus_wr = cyc_i && stb_i && we_i && !ack_o && !err_o && sel_i == 4'hf;
   assign bus_rd = cyc_i && stb_i && !we_i && !ack_o && !err_o;
   assign clear_cmd = bus_wr && adr_i[7:2] == `PEM_A_CLEAR;
   assign cur_pos = pos_current(meas.iout);
   assign next_pwr = {1'b0, 23'(meas.vin * cur_pos)};
   assign pwr_norm = pwr_wide[23:8];
   assign acc_sum = {1'b0, en.acc} + {1'b0, pwr_wide};

   // hardware start pin synchronised, rising edge taken as a start
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hw_meta <= 1'b0;
         hw_sync <= 1'b0;
         hw_prev <= 1'b0;
      end
      else
      begin
         hw_meta <= hw_start_i;
         hw_sync <= hw_meta;
         hw_prev <= hw_sync;
      end
   end

   pem_conv u_conv (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(sw_start || (hw_sync && !hw_prev)),
      .stop_i(sw_stop),
      .continuous_i(continuous),
      .vout_en_i(vout_en),
      .avg_i(avg),
      .adc_i(adc_i),
      .busy_o(busy),
      .done_o(done),
      .avg_o(avg_s)
   );

   // software registers; start and stop are one-cycle strobes
   always_ff @(posedge clk_i)
   begin
      sw_start <= 1'b0;
      sw_stop <= 1'b0;
      if (rst_i)
      begin
         continuous <= 1'b0;
         vout_en <= 1'b0;
         range_high <= 1'b1;
         avg <= 2'h0;
         pin_mode <= pem_pkg::PEM_PIN_ALERT;
         gpo_level <= 1'b0;
         alert_mask <= '0;
         cmp_sel <= 3'h0;
         vin_ov <= `PEM_OV_RESET;
         vin_uv <= `PEM_UV_RESET;
         vout_ov <= `PEM_OV_RESET;
         vout_uv <= `PEM_UV_RESET;
         iout_oc <= `PEM_OV_RESET;
         pwr_op <= `PEM_PWR_OP_RESET;
      end
      else if (bus_wr)
      begin
         unique case (adr_i[7:2])
            `PEM_A_CTRL:
            begin
               sw_start <= dat_i[0];
               sw_stop <= dat_i[1];
            end
            `PEM_A_SETUP:
            begin
               // changes while busy may give spurious data; host stops first
               continuous <= dat_i[0];
               vout_en <= dat_i[1];
               range_high <= dat_i[2];
               avg <= dat_i[5:4];
            end
            `PEM_A_ALERT:
            begin
               pin_mode <= dat_i[1:0] == 2'h0 ? pem_pkg::PEM_PIN_GPO :
                  dat_i[1:0] == 2'h2 ? pem_pkg::PEM_PIN_CMP : pem_pkg::PEM_PIN_ALERT;
               gpo_level <= dat_i[2];
               cmp_sel <= dat_i[6:4];
               alert_mask <= dat_i[8 +: `PEM_NSTAT];
            end
            `PEM_A_VIN_OV: vin_ov <= dat_i[11:0];
            `PEM_A_VIN_UV: vin_uv <= dat_i[11:0];
            `PEM_A_VOUT_OV: vout_ov <= dat_i[11:0];
            `PEM_A_VOUT_UV: vout_uv <= dat_i[11:0];
            `PEM_A_IOUT_OC: iout_oc <= dat_i[11:0];
            `PEM_A_PWR_OP: pwr_op <= dat_i[15:0];
            default:;
         endcase
      end
   end

   // latest averaged sample and its power one cycle later
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meas <= '0;
         pwr_valid <= 1'b0;
      end
      else
      begin
         pwr_valid <= done;
         if (done)
         begin
            meas <= avg_s;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pwr_wide <= 24'h000000;
      end
      else if (pwr_valid)
      begin
         pwr_wide <= next_pwr;
      end
   end

   // energy: acc sees power the cycle after it is computed
   logic acc_go;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_go <= 1'b0;
         en <= '0;
      end
      else
      begin
         acc_go <= pwr_valid;
         if (acc_go)
         begin
            en.acc <= {1'b0, acc_sum[22:0]};
            if (acc_sum[23])
            begin
               en.roll <= en.roll + 16'h0001;
            end
            en.cnt <= en.cnt + 24'h000001;
         end
      end
   end

   // peaks; a zero write to a peak clears it, and the write wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pk_iout <= 12'h000;
         pk_vin <= 12'h000;
         pk_vout <= 12'h000;
         pk_pwr <= 16'h0000;
      end
      else
      begin
         if (bus_wr && adr_i[7:2] == `PEM_A_PK_IOUT && dat_i == 32'h0)
            pk_iout <= 12'h000;
         else if (done && above({4'h0, avg_s.iout}, {4'h0, pk_iout}))
            pk_iout <= avg_s.iout;
         if (bus_wr && adr_i[7:2] == `PEM_A_PK_VIN && dat_i == 32'h0)
            pk_vin <= 12'h000;
         else if (done && above({4'h0, avg_s.vin}, {4'h0, pk_vin}))
            pk_vin <= avg_s.vin;
         if (bus_wr && adr_i[7:2] == `PEM_A_PK_VOUT && dat_i == 32'h0)
            pk_vout <= 12'h000;
         else if (done && above({4'h0, avg_s.vout}, {4'h0, pk_vout}))
            pk_vout <= avg_s.vout;
         if (bus_wr && adr_i[7:2] == `PEM_A_PK_PWR && dat_i == 32'h0)
            pk_pwr <= 16'h0000;
         else if (acc_go && above(pwr_norm, pk_pwr))
            pk_pwr <= pwr_norm;
      end
   end

   // live conditions: vin ov, vin uv, vout ov, vout uv, iout oc, power op
   always_comb
   begin
      cond[0] = above({4'h0, meas.vin}, {4'h0, vin_ov});
      cond[1] = above({4'h0, vin_uv}, {4'h0, meas.vin});
      cond[2] = vout_en && above({4'h0, meas.vout}, {4'h0, vout_ov});
      cond[3] = vout_en && above({4'h0, vout_uv}, {4'h0, meas.vout});
      cond[4] = above({4'h0, cur_pos}, {4'h0, iout_oc});
      cond[5] = above(pwr_norm, pwr_op);
   end

   // clear drops bits, live condition sets them again in the same edge
   always_comb
   begin
      next_status = clear_cmd ? '0 : status;
      next_status = next_status | cond;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status <= '0;
      end
      else
      begin
         status <= next_status;
      end
   end

   // pin drive; gpo ignores masks entirely
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         multipurpose_alert_pin_o <= 1'b0;
      end
      else
      begin
         unique case (pin_mode)
            pem_pkg::PEM_PIN_GPO: multipurpose_alert_pin_o <= gpo_level;
            pem_pkg::PEM_PIN_ALERT: multipurpose_alert_pin_o <= |(status & alert_mask);
            // selects 6 and 7 name no condition, so the pin reads low there
            pem_pkg::PEM_PIN_CMP: multipurpose_alert_pin_o <= (cmp_sel < 3'h6) && cond[cmp_sel];
         endcase
      end
   end

   // read mux
   always_comb
   begin
      map_hit = 1'b1;
      unique case (adr_i[7:2])
         `PEM_A_CTRL: rd_word = {31'h0, busy};
         `PEM_A_SETUP: rd_word = {26'h0, avg, 1'b0, range_high, vout_en, continuous};
         `PEM_A_ALERT: rd_word = {18'h0, alert_mask, 1'b0, cmp_sel, 1'b0, gpo_level, pin_mode};
         `PEM_A_STATUS: rd_word = {26'h0, status};
         `PEM_A_VIN: rd_word = {20'h0, meas.vin};
         `PEM_A_VOUT: rd_word = {20'h0, meas.vout};
         `PEM_A_IOUT: rd_word = {20'h0, meas.iout};
         `PEM_A_PWR: rd_word = {16'h0, pwr_norm};
         `PEM_A_PWR_WIDE: rd_word = {8'h0, pwr_wide};
         `PEM_A_EN_SHORT0: rd_word = {en.acc[23:8], en.roll[7:0], 8'h0};
         `PEM_A_EN_SHORT1: rd_word = {8'h0, en.cnt};
         // 64 bits packed tight so no count bit is lost
         `PEM_A_EN_WIDE0: rd_word = {en.roll, en.acc[23:8]};
         `PEM_A_EN_WIDE1: rd_word = {en.acc[7:0], en.cnt};
         `PEM_A_PK_IOUT: rd_word = {20'h0, pk_iout};
         `PEM_A_PK_VIN: rd_word = {20'h0, pk_vin};
         `PEM_A_PK_VOUT: rd_word = {20'h0, pk_vout};
         `PEM_A_PK_PWR: rd_word = {16'h0, pk_pwr};
         `PEM_A_VIN_OV: rd_word = {20'h0, vin_ov};
         `PEM_A_VIN_UV: rd_word = {20'h0, vin_uv};
         `PEM_A_VOUT_OV: rd_word = {20'h0, vout_ov};
         `PEM_A_VOUT_UV: rd_word = {20'h0, vout_uv};
         `PEM_A_IOUT_OC: rd_word = {20'h0, iout_oc};
         `PEM_A_PWR_OP: rd_word = {16'h0, pwr_op};
         `PEM_A_CLEAR: rd_word = 32'h0;
         default:
         begin
            rd_word = 32'h0;
            map_hit = 1'b0;
         end
      endcase
   end

   // one-wait-state slave: ack or err the edge after request, dropped next
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0;
         range_high_o <= 1'b1;
      end
      else
      begin
         range_high_o <= range_high;
         ack_o <= (bus_rd && map_hit) || (bus_wr && map_hit);
         err_o <= (bus_rd && !map_hit) || (cyc_i && stb_i && we_i && !ack_o && !err_o
            && (!map_hit || sel_i != 4'hf));
         dat_o <= bus_rd ? rd_word : 32'h0;
      end
   end

   // status bit stays set while nothing clears it
   property p_latch;
      @(posedge clk_i) disable iff (rst_i)
      ($past(status[0]) && !$past(clear_cmd)) |-> status[0];
   endproperty
   a_latch: assert property (p_latch) else $error("status bit lost without clear");
   property p_clear;
      @(posedge clk_i) disable iff (rst_i)
      (clear_cmd && !cond[1]) |=> !status[1];
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not drop ended bit");
   property p_reset_live;
      @(posedge clk_i) disable iff (rst_i)
      (clear_cmd && cond[4]) |=> status[4];
   endproperty
   a_reset_live: assert property (p_reset_live) else $error("live bit not reset");
   property p_gpo;
      @(posedge clk_i) disable iff (rst_i)
      (pin_mode == pem_pkg::PEM_PIN_GPO) |=> multipurpose_alert_pin_o == $past(gpo_level);
   endproperty
   a_gpo: assert property (p_gpo) else $error("gpo pin not software driven");
   property p_cnt;
      @(posedge clk_i) disable iff (rst_i)
      acc_go |=> en.cnt == $past(en.cnt) + 24'h000001;
   endproperty
   a_cnt: assert property (p_cnt) else $error("sample counter missed");
   property p_msb;
      @(posedge clk_i) disable iff (rst_i)
      !en.acc[23] && !pwr_wide[23];
   endproperty
   a_msb: assert property (p_msb) else $error("msb not zero");
   property p_roll;
      @(posedge clk_i) disable iff (rst_i)
      (acc_go && acc_sum[23]) |=> en.roll == $past(en.roll) + 16'h0001;
   endproperty
   a_roll: assert property (p_roll) else $error("rollover not counted");
   property p_neg;
      @(posedge clk_i) disable iff (rst_i)
      (pwr_valid && meas.iout <= `PEM_CUR_ZERO) |=> pwr_wide == 24'h000000;
   endproperty
   a_neg: assert property (p_neg) else $error("negative current gave power");
   property p_strict;
      @(posedge clk_i) disable iff (rst_i)
      (meas.vin == vin_ov) |-> !cond[0];
   endproperty
   a_strict: assert property (p_strict) else $error("equality triggered warning");
endmodule // pem_monitor
